// ===== pkg/swbd_if.sv
`timescale 1ns/1ps
interface swbd_if;
    logic host_out;
    logic host_oe;
    logic dev_out;
    logic dev_oe;
    logic wire_level;
    // Pull-up keeps the wire high when nobody drives it.
    assign wire_level = (host_oe && !host_out) || (dev_oe && !dev_out) ? 1'b0 : 1'b1;
    modport device (input wire_level, output dev_out, output dev_oe);
    modport host (input wire_level, output host_out, output host_oe);
endinterface

// ===== pkg/swbd_pkg.sv
package swbd_pkg;
    typedef logic [7:0]  swbd_byte_t;
    typedef logic [15:0] swbd_word_t;
    typedef enum logic [2:0] {
        SWBD_IDLE  = 3'b000,
        SWBD_WAIT  = 3'b001,
        SWBD_LOW   = 3'b011,
        SWBD_DRIVE = 3'b010,
        SWBD_HIGH  = 3'b110
    } swbd_bit_e;
endpackage

// ===== pkg/swbd_regs.svh
`ifndef SWBD_REGS_SVH
`define SWBD_REGS_SVH

// ****************************************************************
// Bit timing in debug clock cycles.
// ****************************************************************
`define SWBD_BIT_CYCLES     16
`define SWBD_SAMPLE_CYCLE   10
`define SWBD_ZERO_LOW       13
`define SWBD_ONE_SPEEDUP    7
`define SWBD_TIMEOUT        512
`define SWBD_SYNC_LOW       128
`define SWBD_SPEEDUP_LEN    1
`define SWBD_HOST_LOW       2

// ****************************************************************
// Command codes.
// ****************************************************************
`define SWBD_CMD_BACKGROUND 8'h90
`define SWBD_CMD_RD_STATUS  8'he4
`define SWBD_CMD_WR_CONTROL 8'hc4
`define SWBD_CMD_RD_BYTE    8'he0
`define SWBD_CMD_WR_BYTE    8'hc0
`define SWBD_CMD_RD_BKPT    8'he2
`define SWBD_CMD_WR_BKPT    8'hc2
`define SWBD_CMD_GO         8'h08
`define SWBD_CMD_STEP       8'h10
`define SWBD_CMD_RD_ACC     8'h68

// ****************************************************************
// Status and control register fields and reset value.
// ****************************************************************
`define SWBD_SC_ENABLE      7
`define SWBD_SC_HALTED      6
`define SWBD_SC_BKPT_EN     5
`define SWBD_SC_CLK_SEL     2
`define SWBD_SC_RESET       8'h00

`endif

// ===== rtl/swbd_device.sv
`timescale 1ns/1ps
`include "swbd_regs.svh"
module swbd_device (
    swbd_if.device               dw,            // Debug wire pin.
    input  wire logic            ref_clk,       // System clock.
    input  wire logic            nrst,          // Asynchronous reset, active low.
    input  wire logic            alt_tick,      // Alternate low clock enable pulse.
    input  wire logic            core_stopped,  // Core in stop or wait.
    input  wire swbd_pkg::swbd_byte_t mem_rdata, // Memory read data.
    input  wire swbd_pkg::swbd_byte_t acc_value, // Accumulator value.
    input  wire swbd_pkg::swbd_word_t core_addr, // Core fetch address.
    output logic                 halted,        // Core held in halted debug mode.
    output logic                 wake_core,     // Wake request to the core.
    output logic                 go_pulse,      // Resume execution.
    output logic                 step_pulse,    // Single step command.
    output logic                 bkpt_hit,      // Breakpoint match halts core.
    output logic                 wdog_block,    // Watchdog hold.
    output logic                 osc_keep,      // Keep oscillator in stop.
    output logic                 mem_we,        // Memory write strobe.
    output logic                 mem_re,        // Memory read strobe.
    output swbd_pkg::swbd_word_t mem_addr,      // Memory address.
    output swbd_pkg::swbd_byte_t mem_wdata      // Memory write data.
);
    import swbd_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    swbd_bit_e  st, next_st;
    logic [9:0] cnt, next_cnt;
    logic [9:0] idle, next_idle;
    logic       prev, next_prev;
    logic       rst_seen, next_rst_seen;
    logic       tx, next_tx;
    logic       txbit, next_txbit;
    logic [4:0] nbits, next_nbits;
    logic [15:0] sh, next_sh;
    logic [7:0] cmd, next_cmd;
    logic [1:0] phase, next_phase;
    logic [7:0] sc, next_sc;
    logic [15:0] bkpt, next_bkpt;
    logic [15:0] addr, next_addr;
    logic       halt_q, next_halt, wake_q, next_wake;
    logic       dout, next_dout, doe, next_doe;
    logic       we, next_we, re, next_re, go, next_go, stp, next_stp, hit, next_hit;
    logic       tick;

    // The debug clock is the system clock or the alternate low clock.
    assign tick = sc[`SWBD_SC_CLK_SEL] ? alt_tick : 1'b1;

    // Returns true for commands that need the core halted.
    function automatic logic needs_halt(input logic [7:0] c);
        needs_halt = (c == `SWBD_CMD_GO) || (c == `SWBD_CMD_STEP) || (c == `SWBD_CMD_RD_ACC);
    endfunction

    // Number of bits in the first field the host sends after a given command byte.
    function automatic logic [4:0] in_len(input logic [7:0] c);
        case (c)
            `SWBD_CMD_RD_BYTE, `SWBD_CMD_WR_BYTE, `SWBD_CMD_WR_BKPT: in_len = 5'd16;
            `SWBD_CMD_WR_CONTROL:                                   in_len = 5'd8;
            default:                                                in_len = 5'd0;
        endcase
    endfunction

    // ****************************************************************
    // Protocol engine.
    // ****************************************************************
    always_comb begin
        next_st = st; next_cnt = cnt; next_idle = idle; next_prev = prev;
        next_rst_seen = rst_seen; next_tx = tx; next_txbit = txbit; next_nbits = nbits;
        next_sh = sh; next_cmd = cmd; next_phase = phase; next_sc = sc; next_bkpt = bkpt;
        next_addr = addr; next_halt = halt_q; next_dout = dout; next_doe = doe;
        next_we = 1'b0; next_re = 1'b0; next_go = 1'b0; next_stp = 1'b0; next_hit = 1'b0;
        if (!rst_seen) begin
            // First edge after reset: a low wire asks for halted start.
            next_rst_seen = 1'b1;
            next_halt = !dw.wire_level;
            next_sc[`SWBD_SC_ENABLE] = !dw.wire_level;
        end
        if (halt_q == 1'b0 && sc[`SWBD_SC_BKPT_EN] && core_addr == bkpt) begin
            next_halt = 1'b1;
            next_hit = 1'b1;
        end
        if (tick) begin
            // The edge detector only moves on debug clock ticks, so none is lost.
            next_prev = dw.wire_level;
            unique case (st)
                SWBD_IDLE: begin
                    if (prev && !dw.wire_level) begin
                        next_st = SWBD_LOW; next_cnt = 10'd1; next_idle = 10'd0;
                        if (tx && !txbit) begin
                            // A zero reply is driven low from the perceived bit start.
                            next_doe = 1'b1; next_dout = 1'b0;
                        end
                    end else if (phase != 2'd0 || nbits != 5'd8) begin
                        // Any half-finished command, command byte included, can time out.
                        next_idle = idle + 10'd1;
                        if (idle == 10'(`SWBD_TIMEOUT - 1)) begin
                            next_phase = 2'd0; next_nbits = 5'd8; next_tx = 1'b0;
                        end
                    end
                end
                SWBD_LOW: begin
                    next_cnt = cnt + 10'd1;
                    if (cnt == 10'd1 && !tx) begin
                        next_doe = 1'b0;
                    end
                    if (tx && cnt == 10'd1 && !txbit) begin
                        next_doe = 1'b1; next_dout = 1'b0;
                    end
                    if (tx && cnt == 10'(`SWBD_ONE_SPEEDUP) && txbit) begin
                        next_doe = 1'b1; next_dout = 1'b1; next_st = SWBD_DRIVE;
                    end
                    if (tx && cnt == 10'(`SWBD_ZERO_LOW) && !txbit) begin
                        next_dout = 1'b1; next_st = SWBD_DRIVE;
                    end
                    if (!tx && cnt == 10'(`SWBD_SAMPLE_CYCLE)) begin
                        next_sh = {sh[14:0], dw.wire_level};
                        next_nbits = nbits - 5'd1;
                        next_st = SWBD_HIGH;
                    end
                    if (!tx && cnt == 10'(`SWBD_SYNC_LOW) && !dw.wire_level) begin
                        // A long host low would be a sync request; receive bits leave SWBD_LOW at cnt 10, so this never fires.
                        next_st = SWBD_WAIT; next_phase = 2'd0; next_nbits = 5'd8;
                    end
                end
                SWBD_DRIVE: begin
                    next_doe = 1'b0; next_st = SWBD_HIGH;
                    next_sh = {sh[14:0], 1'b0};
                    next_nbits = nbits - 5'd1;
                end
                SWBD_WAIT: begin
                    // Sync reply: wait for release, then drive low a fixed time.
                    if (dw.wire_level && !doe) begin
                        next_doe = 1'b1; next_dout = 1'b0; next_cnt = 10'd0;
                    end else if (doe) begin
                        next_cnt = cnt + 10'd1;
                        if (cnt == 10'(`SWBD_SYNC_LOW - 1)) begin
                            next_dout = 1'b1; next_st = SWBD_DRIVE; next_nbits = 5'd9;
                        end
                    end
                end
                SWBD_HIGH: begin
                    next_st = SWBD_IDLE; next_idle = 10'd0; next_tx = 1'b0;
                    if (nbits == 5'd0) begin
                        // Field complete: advance the command.
                        if (phase == 2'd0) begin
                            next_cmd = sh[7:0];
                            if (needs_halt(sh[7:0]) && !halt_q) begin
                                next_nbits = 5'd8;
                            end else if (sh[7:0] == `SWBD_CMD_BACKGROUND) begin
                                next_nbits = 5'd8;
                                if (sc[`SWBD_SC_ENABLE]) begin
                                    next_halt = 1'b1;
                                end
                            end else if (sh[7:0] == `SWBD_CMD_GO) begin
                                next_halt = 1'b0; next_go = 1'b1; next_nbits = 5'd8;
                            end else if (sh[7:0] == `SWBD_CMD_STEP) begin
                                next_stp = 1'b1; next_nbits = 5'd8;
                            end else if (in_len(sh[7:0]) != 5'd0) begin
                                next_phase = 2'd1; next_nbits = in_len(sh[7:0]);
                            end else begin
                                next_phase = 2'd2; next_nbits = 5'd16; next_tx = 1'b1;
                                next_sh = (sh[7:0] == `SWBD_CMD_RD_BKPT) ? bkpt :
                                          (sh[7:0] == `SWBD_CMD_RD_ACC) ? {acc_value, 8'h00} :
                                          {sc | {1'b0, halt_q, 6'h00}, 8'h00};
                                if (sh[7:0] != `SWBD_CMD_RD_BKPT) begin
                                    next_nbits = 5'd8;
                                end
                            end
                        end else if (phase == 2'd1) begin
                            next_phase = 2'd0; next_nbits = 5'd8;
                            if (cmd == `SWBD_CMD_WR_CONTROL) begin
                                next_sc = sh[7:0];
                            end else if (cmd == `SWBD_CMD_WR_BKPT) begin
                                next_bkpt = sh;
                            end else if (cmd == `SWBD_CMD_WR_BYTE) begin
                                next_addr = sh; next_phase = 2'd3;
                            end else begin
                                next_addr = sh; next_re = 1'b1; next_phase = 2'd2;
                                next_tx = 1'b1; next_sh = {mem_rdata, 8'h00};
                            end
                        end else if (phase == 2'd3) begin
                            next_we = 1'b1; next_phase = 2'd0; next_nbits = 5'd8;
                        end else begin
                            next_phase = 2'd0; next_nbits = 5'd8;
                        end
                    end else begin
                        next_tx = (phase == 2'd2);
                    end
                    next_txbit = next_sh[15];
                end
                default: next_st = SWBD_IDLE;
            endcase
        end
        // The wake request is the halt state it will hold next, ANDed with core_stopped.
        next_wake = next_halt & core_stopped;
    end

    // Registers the engine state.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= SWBD_IDLE; cnt <= 10'd0; idle <= 10'd0; prev <= 1'b1;
            rst_seen <= 1'b0; tx <= 1'b0; txbit <= 1'b0; nbits <= 5'd8; sh <= 16'h0000;
            cmd <= 8'h00; phase <= 2'd0; sc <= `SWBD_SC_RESET; bkpt <= 16'h0000;
            addr <= 16'h0000; halt_q <= 1'b0; dout <= 1'b1; doe <= 1'b0; wake_q <= 1'b0;
            we <= 1'b0; re <= 1'b0; go <= 1'b0; stp <= 1'b0; hit <= 1'b0;
        end else begin
            st <= next_st; cnt <= next_cnt; idle <= next_idle; prev <= next_prev;
            rst_seen <= next_rst_seen; tx <= next_tx; txbit <= next_txbit;
            nbits <= next_nbits; sh <= next_sh; cmd <= next_cmd; phase <= next_phase;
            sc <= next_sc; bkpt <= next_bkpt; addr <= next_addr; halt_q <= next_halt;
            dout <= next_dout; doe <= next_doe; we <= next_we; re <= next_re;
            go <= next_go; stp <= next_stp; hit <= next_hit; wake_q <= next_wake;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign dw.dev_out  = dout;
    assign dw.dev_oe   = doe;
    assign halted      = halt_q;
    assign wake_core   = wake_q;
    assign wdog_block  = halt_q;
    assign osc_keep    = sc[`SWBD_SC_ENABLE];
    assign go_pulse    = go;
    assign step_pulse  = stp;
    assign bkpt_hit    = hit;
    assign mem_we      = we;
    assign mem_re      = re;
    assign mem_addr    = addr;
    assign mem_wdata   = sh[7:0];
endmodule // swbd_device

// ===== rtl/swbd_host.sv
`timescale 1ns/1ps
`include "swbd_regs.svh"
module swbd_host (
    swbd_if.host                 dw,        // Debug wire pin.
    input  wire logic            ref_clk,   // System clock.
    input  wire logic            nrst,      // Asynchronous reset, active low.
    input  wire logic            bit_req,   // Pulse: start one bit.
    input  wire logic            bit_tx,    // Host sends this bit.
    input  wire logic            bit_val,   // Bit value to send.
    output logic                 busy,      // Bit in progress.
    output logic                 rx_valid,  // Pulse: received bit ready.
    output logic                 rx_bit     // Received bit value.
);
    import swbd_pkg::*;

    // ****************************************************************
    // Bit generator: each bit starts with a host falling edge.
    // ****************************************************************
    logic [4:0] cnt, next_cnt;
    logic       act, next_act, tx, next_tx, val, next_val;
    logic       out, next_out, oe, next_oe, rv, next_rv, rb, next_rb;

    // Computes the next bit-slot values.
    always_comb begin
        next_cnt = cnt; next_act = act; next_tx = tx; next_val = val;
        next_out = out; next_oe = oe; next_rv = 1'b0; next_rb = rb;
        if (!act && bit_req) begin
            next_act = 1'b1; next_cnt = 5'd0; next_tx = bit_tx; next_val = bit_val;
            next_oe = 1'b1; next_out = 1'b0;
        end else if (act) begin
            next_cnt = cnt + 5'd1;
            if (!tx && cnt == 5'(`SWBD_HOST_LOW - 1)) begin
                next_oe = 1'b0;
            end
            if (tx && cnt == 5'(`SWBD_SAMPLE_CYCLE - 2) && val) begin
                next_out = 1'b1;
            end
            if (tx && cnt == 5'(`SWBD_ZERO_LOW)) begin
                next_out = 1'b1;
            end
            if (!tx && cnt == 5'(`SWBD_SAMPLE_CYCLE)) begin
                next_rv = 1'b1; next_rb = dw.wire_level;
            end
            if (cnt == 5'(`SWBD_BIT_CYCLES - 1)) begin
                next_act = 1'b0; next_oe = 1'b0; next_out = 1'b1;
            end
        end
    end

    // Registers the bit-slot state.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 5'd0; act <= 1'b0; tx <= 1'b0; val <= 1'b0;
            out <= 1'b1; oe <= 1'b0; rv <= 1'b0; rb <= 1'b0;
        end else begin
            cnt <= next_cnt; act <= next_act; tx <= next_tx; val <= next_val;
            out <= next_out; oe <= next_oe; rv <= next_rv; rb <= next_rb;
        end
    end

    assign dw.host_out = out;
    assign dw.host_oe  = oe;
    assign busy        = act;
    assign rx_valid    = rv;
    assign rx_bit      = rb;
endmodule // swbd_host

// ===== verification/single_wire_background_debug_tb.sv
`timescale 1ns/1ps
`include "swbd_regs.svh"
module single_wire_background_debug_tb;
    import swbd_pkg::*;
    localparam int D = 2 * `SWBD_BIT_CYCLES;
    logic ref_clk, nrst, bit_req, bit_tx, bit_val, busy, rx_valid, rx_bit;
    logic alt_tick, core_stopped, halted, halted2, wake_core, go_pulse, step_pulse;
    logic wdog_block, osc_keep, mem_we, mem_re, bkpt_hit;
    swbd_byte_t mem_rdata, acc_value, mem_wdata, we_data, b;
    swbd_word_t core_addr, mem_addr, we_addr, w;
    int bad_count = 0, compares = 0, we_n = 0, go_n = 0, step_n = 0, re_n = 0, hit_n = 0;
    logic [23:0] rows [0:2] = '{24'h0000_5a, 24'hffff_a5, 24'h8001_01};

    swbd_if dw ();
    swbd_if dw2 ();
    swbd_device swbd_device_i (.dw(dw.device), .ref_clk(ref_clk), .nrst(nrst),
        .alt_tick(alt_tick), .core_stopped(core_stopped), .mem_rdata(mem_rdata),
        .acc_value(acc_value), .core_addr(core_addr), .halted(halted),
        .wake_core(wake_core), .go_pulse(go_pulse), .step_pulse(step_pulse),
        .bkpt_hit(bkpt_hit), .wdog_block(wdog_block), .osc_keep(osc_keep),
        .mem_we(mem_we), .mem_re(mem_re),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    // Second device whose wire the bench holds low through reset.
    swbd_device swbd_device_i2 (.dw(dw2.device), .ref_clk(ref_clk), .nrst(nrst),
        .alt_tick(alt_tick), .core_stopped(core_stopped), .mem_rdata(mem_rdata),
        .acc_value(acc_value), .core_addr(core_addr), .halted(halted2), .wake_core(),
        .go_pulse(), .step_pulse(), .bkpt_hit(), .wdog_block(), .osc_keep(), .mem_we(),
        .mem_re(), .mem_addr(), .mem_wdata());
    swbd_host swbd_host_i (.dw(dw.host), .ref_clk(ref_clk), .nrst(nrst), .bit_req(bit_req),
        .bit_tx(bit_tx), .bit_val(bit_val), .busy(busy), .rx_valid(rx_valid), .rx_bit(rx_bit));
    swbd_checker swbd_checker_i (.ref_clk(ref_clk), .nrst(nrst), .host_out(dw.host_out),
        .host_oe(dw.host_oe), .dev_out(dw.dev_out), .dev_oe(dw.dev_oe),
        .wire_level(dw.wire_level));

    // Free-running clock of 100 ns period.
    always #50 ref_clk = ~ref_clk;

    // Tallies the strobes that the device raises towards the core.
    always @(posedge ref_clk) begin
        if (mem_we === 1'b1) begin
            we_n <= we_n + 1;
            we_addr <= mem_addr;
            we_data <= mem_wdata;
        end
        if (go_pulse === 1'b1) go_n <= go_n + 1;
        if (step_pulse === 1'b1) step_n <= step_n + 1;
        if (mem_re === 1'b1) re_n <= re_n + 1;
        if (bkpt_hit === 1'b1) hit_n <= hit_n + 1;
    end

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One bit through the host end; a hang counts as a mismatch.
    task automatic xfer(input logic tx, input logic val, output logic got);
        int n;
        got = 1'b0;
        @(posedge ref_clk);
        bit_req <= 1'b1;
        bit_tx  <= tx;
        bit_val <= val;
        @(posedge ref_clk);
        bit_req <= 1'b0;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            #1;
            if (rx_valid === 1'b1) got = rx_bit;
            if (busy !== 1'b1) break;
        end
        if (n == 40) begin
            bad_count++;
            test_done();
        end
    endtask

    // Byte and word movers, most significant bit first.
    task automatic send_byte(input logic [7:0] v);
        logic g;
        for (int i = 7; i >= 0; i--) xfer(1'b1, v[i], g);
    endtask
    task automatic send_word(input logic [15:0] v);
        send_byte(v[15:8]);
        send_byte(v[7:0]);
    endtask
    task automatic recv_byte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) xfer(1'b0, 1'b0, v[i]);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        {bit_req, bit_tx, bit_val, alt_tick, core_stopped} = 5'h00;
        mem_rdata = 8'h3c;
        acc_value = 8'h96;
        core_addr = 16'h0000;
        dw2.host_oe = 1'b1;
        dw2.host_out = 1'b0;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        idle(3);
        check(16'(halted), 16'h0000);
        check(16'(wdog_block), 16'h0000);
        check(16'(halted2), 16'h0001);
        dw2.host_oe <= 1'b0;
        // Halted-only commands are ignored while the core runs.
        send_byte(`SWBD_CMD_GO);
        idle(D);
        send_byte(`SWBD_CMD_STEP);
        idle(D);
        check(16'(go_n), 16'h0000);
        check(16'(step_n), 16'h0000);
        send_byte(`SWBD_CMD_WR_CONTROL);
        send_byte(8'h80);
        idle(D);
        check(16'(osc_keep), 16'h0001);
        // Memory writes while running, one row each.
        for (int r = 0; r < 3; r++) begin
            send_byte(`SWBD_CMD_WR_BYTE);
            send_word(rows[r][23:8]);
            send_byte(rows[r][7:0]);
            idle(D);
            check(16'(we_n), 16'(r + 1));
            check(we_addr, rows[r][23:8]);
            check(16'(we_data), 16'(rows[r][7:0]));
        end
        // Memory read while running returns the byte after the address.
        send_byte(`SWBD_CMD_RD_BYTE);
        send_word(16'h1234);
        recv_byte(b);
        check(16'(b), 16'h003c);
        check(mem_addr, 16'h1234);
        check(16'(re_n), 16'h0001);
        // A halt request wakes a stopped core into halted mode.
        core_stopped <= 1'b1;
        send_byte(`SWBD_CMD_BACKGROUND);
        idle(D);
        check(16'(halted), 16'h0001);
        check(16'(wake_core), 16'h0001);
        check(16'(wdog_block), 16'h0001);
        core_stopped <= 1'b0;
        send_byte(`SWBD_CMD_RD_STATUS);
        recv_byte(b);
        check(16'(b & 8'hc0), 16'h00c0);
        send_byte(`SWBD_CMD_RD_ACC);
        idle(D);
        recv_byte(b);
        check(16'(b), 16'h0096);
        send_byte(`SWBD_CMD_WR_BKPT);
        send_word(16'hc35a);
        send_byte(`SWBD_CMD_RD_BKPT);
        recv_byte(w[15:8]);
        recv_byte(w[7:0]);
        check(w, 16'hc35a);
        // Half of a write command byte, then silence past the timeout.
        for (int i = 0; i < 4; i++) xfer(1'b1, i < 2, b[0]);
        idle(600);
        send_byte(`SWBD_CMD_RD_STATUS);
        recv_byte(b);
        check(16'(b & 8'h40), 16'h0040);
        check(16'(we_n), 16'h0003);
        send_byte(`SWBD_CMD_STEP);
        idle(D);
        check(16'(step_n), 16'h0001);
        send_byte(`SWBD_CMD_GO);
        idle(D);
        check(16'(go_n), 16'h0001);
        check(16'(halted), 16'h0000);
        check(16'(wdog_block), 16'h0000);
        // An enabled breakpoint that matches the fetch address halts the core.
        send_byte(`SWBD_CMD_WR_CONTROL);
        send_byte(8'ha0);
        core_addr <= 16'hc35a;
        idle(3);
        check(16'(halted), 16'h0001);
        check(16'(hit_n), 16'h0001);
        // Second reset in mid-run with the wire idle.
        nrst <= 1'b0;
        idle(3);
        nrst <= 1'b1;
        idle(3);
        check(16'(halted), 16'h0000);
        test_done();
    end
endmodule // single_wire_background_debug_tb

// ===== verification/swbd_checker.sv
`timescale 1ns/1ps
module swbd_checker (
    input wire logic ref_clk,    // System clock.
    input wire logic nrst,       // Asynchronous reset, active low.
    input wire logic host_out,   // Host drive value.
    input wire logic host_oe,    // Host drive enable.
    input wire logic dev_out,    // Device drive value.
    input wire logic dev_oe,     // Device drive enable.
    input wire logic wire_level  // Resolved wire level.
);
    logic       host_oe_q;
    logic [9:0] since_host;
    logic [9:0] next_since_host;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ****************************************************************
    // Cycles since the host last began a bit.
    // ****************************************************************
    // Restarts on each host start and saturates so it never wraps.
    always_comb begin
        next_since_host = since_host;
        if (host_oe && !host_oe_q) begin
            next_since_host = 10'h000;
        end else if (since_host != 10'h3ff) begin
            next_since_host = since_host + 10'h001;
        end
    end

    // Registers the counter and the delayed host enable.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            since_host <= 10'h3ff;
            host_oe_q  <= 1'b0;
        end else begin
            since_host <= next_since_host;
            host_oe_q  <= host_oe;
        end
    end

    // ****************************************************************
    // Wire assertions.
    // ****************************************************************
    AST_DEV_FOLLOWS_HOST: assert property ($rose(dev_oe) |-> since_host <= 10'h00c)
        else $error("Device drove the wire without a host bit start.");
    AST_HOST_STARTS_LOW: assert property ($rose(host_oe) |-> !host_out)
        else $error("Host began a bit without driving low.");
    AST_HOST_HOLDS_LOW: assert property ($fell(wire_level) |-> !wire_level [*2])
        else $error("Bit start low shorter than two cycles.");
    AST_BIT_SPACING: assert property ($rose(host_oe) |-> $past(since_host) >= 10'h00e)
        else $error("Host bits closer than one bit time.");
    AST_NO_CONTENTION: assert property (!(host_oe && dev_oe && (host_out != dev_out)))
        else $error("Host and device drive opposite levels.");
    AST_SPEEDUP_ONE_CYCLE: assert property ($rose(dev_oe) && dev_out |=> !dev_oe)
        else $error("Device speedup pulse longer than one cycle.");
    AST_HOST_CLEAR_OF_SPEEDUP: assert property (dev_oe && dev_out |-> !host_oe)
        else $error("Host still driving during device speedup.");
    AST_ZERO_REPLY_LEN: assert property ($rose(dev_oe) && !dev_out |->
        (dev_oe && !dev_out) [*8] ##1 (dev_oe && !dev_out) [*5] ##1 (dev_oe && dev_out)
        ##1 !dev_oe)
        else $error("Zero reply not thirteen low cycles and one high.");
    AST_RESET_RELEASED: assert property ($rose(nrst) |-> !dev_oe && !host_oe)
        else $error("Wire driven right after reset.");

    COV_ZERO_REPLY: cover property ($rose(dev_oe) && !dev_out);
    COV_ONE_SPEEDUP: cover property ($rose(dev_oe) && dev_out);
    COV_HOST_BIT: cover property ($rose(host_oe));
endmodule // swbd_checker
